// File: include/otp_prog_consts.vh
// constants for the otp programmer controller
// Notes on behaviour
// - each byte is written by a low program strobe of nominally 100 us with address and data held.
// - every program strobe lasts no less than 95 us and no more than 105 us.
// - programming starts with the address set to the lowest location.
// - core supply goes to 6.5 V and programming supply to 13.0 V before and during program/verify.
// - every address first gets exactly one pulse with no verify.
// - in the verify pass a failing byte gets up to 10 more pulses, each followed by a verify read.
// - a byte still failing after ten retry pulses fails the part and stops programming.
// - a byte that verifies moves the pass on to the next address until all are checked.
// - after verifying all, programming supply and core supply drop to 5.0 V before the final check.
// - at the reduced supplies every byte is read and compared; any mismatch fails, else pass.
// - identification mode is entered by holding the id select line at the high id voltage.
// - core supply comes on no later than programming supply and goes off no earlier.
// - verify reads allow for output enable access delay and output float delay.
`ifndef OTP_PROG_CONSTS_VH
`define OTP_PROG_CONSTS_VH
`define CLK_MHZ            25
`define PULSE_NOM_US       100
`define PULSE_MIN_US       95
`define PULSE_MAX_US       105
`define PULSE_CYC          (`PULSE_NOM_US * `CLK_MHZ)
`define SETUP_US           2
`define SETUP_CYC          (`SETUP_US * `CLK_MHZ)
`define OE_ACCESS_NS       150
`define OE_ACCESS_CYC      ((`OE_ACCESS_NS * `CLK_MHZ + 999) / 1000)
`define FLOAT_NS           130
`define FLOAT_CYC          ((`FLOAT_NS * `CLK_MHZ + 999) / 1000)
`define RETRY_MAX          10
`define SUP_OFF            2'h0
`define SUP_READ           2'h1
`define SUP_PROG           2'h2
`endif

// File: verilog/otp_prog_ctrl.v
// controller that programs, verifies and identifies a byte-wide otp memory
`timescale 1ns/100ps
`include "otp_prog_consts.vh"
module otp_prog_ctrl #(
  parameter AW        = 19,
  parameter PULSE_CYC = `PULSE_CYC,
  parameter SETUP_CYC = `SETUP_CYC
) (
  input  wire          core_clk,
  input  wire          rst_n,
  input  wire          start_prog,
  input  wire          start_id,
  input  wire [AW-1:0] last_addr,
  input  wire [7:0]    src_data,
  input  wire [7:0]    mem_data_in,
  output reg  [AW-1:0] mem_addr_r,
  output reg  [7:0]    mem_data_out_r,
  output reg           mem_data_oe_r,
  output reg           chip_en_n_r,
  output reg           out_en_n_r,
  output reg           id_entry_high_voltage_r,
  output reg  [1:0]    core_supply_r,
  output reg  [1:0]    prog_supply_r,
  output reg  [AW-1:0] src_addr_r,
  output reg           busy_r,
  output reg           done_r,
  output reg           pass_r,
  output reg  [7:0]    maker_code_r,
  output reg  [7:0]    type_code_r
);

////////////////////////////////////////////////////////////////////////////////
localparam S_IDLE    = 4'h0;
localparam S_VCC_UP  = 4'h1;
localparam S_VPP_UP  = 4'h2;
localparam S_SET     = 4'h3;
localparam S_PULSE   = 4'h4;
localparam S_HOLD    = 4'h5;
localparam S_OE      = 4'h6;
localparam S_SAMPLE  = 4'h7;
localparam S_FLOAT   = 4'h8;
localparam S_VPP_DN  = 4'h9;
localparam S_VCC_DN  = 4'hA;
localparam S_FINAL   = 4'hB;
localparam S_OFF     = 4'hC;
localparam S_ID      = 4'hD;

localparam P_BLIND  = 2'h0;
localparam P_VERIFY = 2'h1;
localparam P_FINAL  = 2'h2;
localparam P_ID     = 2'h3;

localparam CW = 17;
localparam integer  OE_I    = `OE_ACCESS_CYC;
localparam integer  FLT_I   = `FLOAT_CYC;
localparam integer  RETRY_I = `RETRY_MAX;
// counts are cut to the counter width on purpose
localparam [CW-1:0] PULSE_N = PULSE_CYC[CW-1:0];
localparam [CW-1:0] SETUP_N = SETUP_CYC[CW-1:0];
localparam [CW-1:0] OE_N    = OE_I[CW-1:0];
localparam [CW-1:0] FLT_N   = FLT_I[CW-1:0];
localparam [3:0]    RETRY_N = RETRY_I[3:0];

reg [7:0]    din_s1_r;
reg [7:0]    din_s2_r;
reg [3:0]    state_r;
reg [1:0]    phase_r;
reg [CW-1:0] cnt_r;
reg [3:0]    retry_r;
reg          fail_r;

function last_word;
  input [AW-1:0] a;
  input [AW-1:0] l;
  begin
    last_word = (a == l);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// two-stage sync of the device data bus
always @(posedge core_clk or negedge rst_n) begin
  if (!rst_n) begin
    din_s1_r <= 8'h00;
    din_s2_r <= 8'h00;
  end else begin
    din_s1_r <= mem_data_in;
    din_s2_r <= din_s1_r;
  end
end

always @(posedge core_clk or negedge rst_n) begin
  if (!rst_n) begin
    state_r                 <= S_IDLE;
    phase_r                 <= P_BLIND;
    cnt_r                   <= {CW{1'b0}};
    retry_r                 <= 4'h0;
    fail_r                  <= 1'b0;
    mem_addr_r              <= {AW{1'b0}};
    mem_data_out_r          <= 8'h00;
    mem_data_oe_r           <= 1'b0;
    chip_en_n_r             <= 1'b1;
    out_en_n_r              <= 1'b1;
    id_entry_high_voltage_r <= 1'b0;
    core_supply_r           <= `SUP_OFF;
    prog_supply_r           <= `SUP_OFF;
    src_addr_r              <= {AW{1'b0}};
    busy_r                  <= 1'b0;
    done_r                  <= 1'b0;
    pass_r                  <= 1'b0;
    maker_code_r            <= 8'h00;
    type_code_r             <= 8'h00;
  end else begin
    done_r <= 1'b0;
    case (state_r)
      S_IDLE: begin
        cnt_r <= {CW{1'b0}};
        if (start_prog) begin
          busy_r        <= 1'b1;
          fail_r        <= 1'b0;
          phase_r       <= P_BLIND;
          mem_addr_r    <= {AW{1'b0}};
          src_addr_r    <= {AW{1'b0}};
          core_supply_r <= `SUP_PROG;
          state_r       <= S_VCC_UP;
        end else if (start_id) begin
          busy_r                  <= 1'b1;
          phase_r                 <= P_ID;
          core_supply_r           <= `SUP_READ;
          mem_addr_r              <= {AW{1'b0}};
          id_entry_high_voltage_r <= 1'b1;
          state_r                 <= S_VCC_UP;
        end
      end
      S_VCC_UP: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r <= {CW{1'b0}};
          if (phase_r == P_ID) begin
            state_r <= S_ID;
          end else begin
            prog_supply_r <= `SUP_PROG;
            state_r       <= S_VPP_UP;
          end
        end
      end
      S_VPP_UP: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r   <= {CW{1'b0}};
          state_r <= S_SET;
        end
      end
      S_SET: begin
        // address and data settle before the strobe falls
        mem_data_out_r <= src_data;
        mem_data_oe_r  <= 1'b1;
        cnt_r          <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r       <= {CW{1'b0}};
          chip_en_n_r <= 1'b0;
          state_r     <= S_PULSE;
        end
      end
      S_PULSE: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == PULSE_N - 1'b1) begin
          cnt_r       <= {CW{1'b0}};
          chip_en_n_r <= 1'b1;
          state_r     <= S_HOLD;
        end
      end
      S_HOLD: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r         <= {CW{1'b0}};
          mem_data_oe_r <= 1'b0;
          if (phase_r == P_BLIND) begin
            if (last_word(mem_addr_r, last_addr)) begin
              phase_r    <= P_VERIFY;
              mem_addr_r <= {AW{1'b0}};
              src_addr_r <= {AW{1'b0}};
              retry_r    <= 4'h0;
              state_r    <= S_OE;
            end else begin
              mem_addr_r <= mem_addr_r + 1'b1;
              src_addr_r <= src_addr_r + 1'b1;
              state_r    <= S_SET;
            end
          end else begin
            state_r <= S_OE;
          end
        end
      end
      S_OE: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r      <= {CW{1'b0}};
          out_en_n_r <= 1'b0;
          state_r    <= S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        // wait access delay plus two sync stages
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == OE_N + 2'h2) begin
          cnt_r      <= {CW{1'b0}};
          out_en_n_r <= 1'b1;
          state_r    <= S_FLOAT;
          if (phase_r == P_ID) begin
            if (mem_addr_r[0]) begin
              type_code_r <= din_s2_r;
            end else begin
              maker_code_r <= din_s2_r;
            end
          end else if (din_s2_r != src_data) begin
            if (phase_r == P_FINAL) begin
              fail_r <= 1'b1;
            end else if (retry_r == RETRY_N) begin
              fail_r <= 1'b1;
            end else begin
              retry_r <= retry_r + 1'b1;
            end
          end else begin
            retry_r <= 4'h0;
          end
        end
      end
      S_FLOAT: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == FLT_N) begin
          cnt_r <= {CW{1'b0}};
          if (phase_r == P_ID) begin
            if (mem_addr_r[0]) begin
              id_entry_high_voltage_r <= 1'b0;
              state_r                 <= S_VCC_DN;
            end else begin
              mem_addr_r <= {{(AW-1){1'b0}}, 1'b1};
              state_r    <= S_OE;
            end
          end else if (fail_r && phase_r == P_VERIFY) begin
            prog_supply_r <= `SUP_OFF;
            state_r       <= S_VCC_DN;
          end else if (phase_r == P_VERIFY && retry_r != 4'h0) begin
            state_r <= S_SET;
          end else if (last_word(mem_addr_r, last_addr)) begin
            if (phase_r == P_VERIFY) begin
              prog_supply_r <= `SUP_READ;
              state_r       <= S_VPP_DN;
            end else begin
              prog_supply_r <= `SUP_OFF;
              state_r       <= S_VCC_DN;
            end
          end else begin
            mem_addr_r <= mem_addr_r + 1'b1;
            src_addr_r <= src_addr_r + 1'b1;
            state_r    <= S_OE;
          end
        end
      end
      S_VPP_DN: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r         <= {CW{1'b0}};
          core_supply_r <= `SUP_READ;
          state_r       <= S_FINAL;
        end
      end
      S_FINAL: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r      <= {CW{1'b0}};
          phase_r    <= P_FINAL;
          mem_addr_r <= {AW{1'b0}};
          src_addr_r <= {AW{1'b0}};
          state_r    <= S_OE;
        end
      end
      S_ID: begin
        cnt_r   <= {CW{1'b0}};
        state_r <= S_OE;
      end
      S_VCC_DN: begin
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == SETUP_N) begin
          cnt_r         <= {CW{1'b0}};
          core_supply_r <= `SUP_OFF;
          state_r       <= S_OFF;
        end
      end
      S_OFF: begin
        busy_r  <= 1'b0;
        done_r  <= 1'b1;
        pass_r  <= (phase_r == P_ID) ? 1'b1 : !fail_r;
        state_r <= S_IDLE;
      end
      default: begin
        state_r <= S_IDLE;
      end
    endcase
  end
end

endmodule // otp_prog_ctrl

// File: bench/otp_prog_properties.sv
// concurrent checks on the otp programmer controller ports
`timescale 1ns/100ps
module otp_prog_properties #(parameter AW = 19, parameter PULSE_CYC = 2500) (
  input wire          core_clk,
  input wire          rst_n,
  input wire          busy_r,
  input wire          done_r,
  input wire          pass_r,
  input wire          chip_en_n_r,
  input wire          out_en_n_r,
  input wire          mem_data_oe_r,
  input wire          id_entry_high_voltage_r,
  input wire [AW-1:0] mem_addr_r,
  input wire [7:0]    mem_data_out_r,
  input wire [1:0]    core_supply_r,
  input wire [1:0]    prog_supply_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  integer lo_cnt_r;
  reg     busy_d_r;
  reg     first_r;
  // first_r marks a run whose first strobe has not yet fallen
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt_r <= 0;
      busy_d_r <= 1'b0;
      first_r  <= 1'b0;
    end else begin
      lo_cnt_r <= chip_en_n_r ? 0 : lo_cnt_r + 1;
      busy_d_r <= busy_r;
      first_r  <= (busy_r && !busy_d_r) || (first_r && chip_en_n_r);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_pulse_width: assert property ($rose(chip_en_n_r) |-> lo_cnt_r == PULSE_CYC)
    else $error("program pulse width wrong");
  a_prog_supplies: assert property (!chip_en_n_r |-> core_supply_r == 2'h2 && prog_supply_r == 2'h2)
    else $error("pulse without program supplies");
  a_supply_order: assert property (core_supply_r >= prog_supply_r)
    else $error("supply order wrong");
  a_pulse_hold: assert property (!chip_en_n_r && !$past(chip_en_n_r) |->
    $stable(mem_addr_r) && $stable(mem_data_out_r) && mem_data_oe_r)
    else $error("address or data moved in pulse");
  a_read_quiet: assert property (!out_en_n_r |-> chip_en_n_r && !mem_data_oe_r)
    else $error("read with strobe or drive");
  a_first_addr: assert property ($fell(chip_en_n_r) && first_r |-> mem_addr_r == 0)
    else $error("first pulse not at lowest address");
  a_access_time: assert property ($fell(out_en_n_r) |-> !out_en_n_r [*4])
    else $error("read shorter than access delay");
  a_float_gap: assert property ($rose(out_en_n_r) |-> (chip_en_n_r && !mem_data_oe_r) [*4])
    else $error("bus reused before float");
  a_done_single: assert property (done_r |=> !done_r)
    else $error("done longer than one cycle");
  a_id_no_prog: assert property (id_entry_high_voltage_r |-> chip_en_n_r && prog_supply_r != 2'h2)
    else $error("id voltage while programming");
  c_pass: cover property (done_r && pass_r);
  c_fail: cover property (done_r && !pass_r);
  c_id: cover property ($rose(id_entry_high_voltage_r));
endmodule // otp_prog_properties

bind otp_prog_ctrl otp_prog_properties #(.AW(AW), .PULSE_CYC(PULSE_CYC)) i_otp_prog_properties (
  .core_clk(core_clk), .rst_n(rst_n), .busy_r(busy_r), .done_r(done_r), .pass_r(pass_r),
  .chip_en_n_r(chip_en_n_r), .out_en_n_r(out_en_n_r), .mem_data_oe_r(mem_data_oe_r),
  .id_entry_high_voltage_r(id_entry_high_voltage_r), .mem_addr_r(mem_addr_r),
  .mem_data_out_r(mem_data_out_r), .core_supply_r(core_supply_r), .prog_supply_r(prog_supply_r));

// File: bench/otp_dev_model.sv
// behavioural model of the one-time programmable memory
`timescale 1ns/100ps
module otp_dev_model #(
  parameter AW = 4,
  parameter ACC = 60,
  parameter [7:0] MAKER = 8'hA5, // arbitrary
  parameter [7:0] TYPE  = 8'h3C  // arbitrary
) (
  input  wire          core_clk,
  input  wire [AW-1:0] addr,
  input  wire [7:0]    d,
  input  wire          d_oe,
  input  wire          ce_n,
  input  wire          oe_n,
  input  wire          id_hv,
  input  wire [1:0]    core,
  input  wire [1:0]    prog,
  input  wire          weak_en,
  input  wire [AW-1:0] weak_addr,
  output wire [7:0]    q
);
  reg [7:0] mem [0:15];
  integer   cnt [0:15];
  integer   need [0:15];
  reg       ce_d_r = 1'b1;
  reg [7:0] last_r = 8'h00;
  wire      rd = !oe_n && ce_n;
  // a weak cell reads right only at the program core supply
  wire [7:0] val = id_hv ? (addr[0] ? TYPE : MAKER) :
    (weak_en && addr == weak_addr && core != 2'h2) ? ~mem[addr] : mem[addr];
  // released bus shows the inverse of the last value
  assign #(ACC) q = rd ? val : ~last_r;
  always @(posedge core_clk) begin
    ce_d_r <= ce_n;
    if (rd)
      last_r <= val;
    if (ce_n && !ce_d_r && core == 2'h2 && prog == 2'h2 && d_oe) begin
      cnt[addr] <= cnt[addr] + 1;
      if (cnt[addr] + 1 >= need[addr])
        mem[addr] <= mem[addr] & d;
    end
  end
endmodule // otp_dev_model

// File: bench/tb.sv
// self-checking bench for the otp programmer controller
`timescale 1ns/100ps
module tb;
  localparam AW = 4;
  localparam LA = 3;
  reg           core_clk, rst_n, start_prog, start_id, weak_en;
  reg  [AW-1:0] last_addr, weak_addr;
  reg  [7:0]    src [0:15];
  integer       mismatches, tests_run, seed, cyc, i, a, ep, ok, stp, nd;
  wire [AW-1:0] mem_addr_r, src_addr_r;
  wire [7:0]    mem_data_out_r, mem_data_in, maker_code_r, type_code_r;
  wire [1:0]    core_supply_r, prog_supply_r;
  wire          mem_data_oe_r, chip_en_n_r, out_en_n_r, id_entry_high_voltage_r;
  wire          busy_r, done_r, pass_r;
  wire [7:0]    src_data = src[src_addr_r];
  otp_prog_ctrl #(.AW(AW), .PULSE_CYC(20), .SETUP_CYC(3)) i_otp_prog_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .start_prog(start_prog), .start_id(start_id),
    .last_addr(last_addr), .src_data(src_data), .mem_data_in(mem_data_in),
    .mem_addr_r(mem_addr_r), .mem_data_out_r(mem_data_out_r), .mem_data_oe_r(mem_data_oe_r),
    .chip_en_n_r(chip_en_n_r), .out_en_n_r(out_en_n_r),
    .id_entry_high_voltage_r(id_entry_high_voltage_r), .core_supply_r(core_supply_r),
    .prog_supply_r(prog_supply_r), .src_addr_r(src_addr_r), .busy_r(busy_r),
    .done_r(done_r), .pass_r(pass_r), .maker_code_r(maker_code_r), .type_code_r(type_code_r));
  otp_dev_model #(.AW(AW)) i_otp_dev_model (
    .core_clk(core_clk), .addr(mem_addr_r), .d(mem_data_out_r), .d_oe(mem_data_oe_r),
    .ce_n(chip_en_n_r), .oe_n(out_en_n_r), .id_hv(id_entry_high_voltage_r),
    .core(core_supply_r), .prog(prog_supply_r), .weak_en(weak_en), .weak_addr(weak_addr),
    .q(mem_data_in));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (mismatches == 0 && tests_run > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // p high starts a program run with an id start alongside, low an id read
  task go(input p);
    integer n;
    begin
      @(posedge core_clk) #1;
      start_prog = p;
      start_id = 1'b1;
      @(posedge core_clk) #1;
      start_prog = 1'b0;
      start_id = 1'b0;
      check(busy_r, 1'b1);
      n = 0;
      while (done_r !== 1'b1 && n < 20000) begin
        @(posedge core_clk) #1;
        // a start while busy must be ignored
        start_id = (n == 4);
        n = n + 1;
      end
      start_id = 1'b0;
      check(done_r, 1'b1);
      repeat (2) @(posedge core_clk);
      #1 check(busy_r, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  initial begin
    seed = 41; mismatches = 0; tests_run = 0; cyc = 0;
    rst_n = 1'b0; start_prog = 1'b0; start_id = 1'b0; weak_en = 1'b0;
    weak_addr = 4'h2; last_addr = LA;
    for (a = 0; a < 16; a = a + 1)
      src[a] = 8'h00;
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1'b1;
    // plain, ten-retry boundary, retry exhaustion, weak final read
    for (i = 0; i < 4; i = i + 1) begin
      for (a = 0; a < 16; a = a + 1) begin
        src[a] = $random(seed);
        i_otp_dev_model.mem[a] = 8'hFF;
        i_otp_dev_model.cnt[a] = 0;
        i_otp_dev_model.need[a] = {$random(seed)} % 4 + 1;
      end
      if (i == 1) i_otp_dev_model.need[2] = 11;
      if (i == 2) i_otp_dev_model.need[1] = 12;
      weak_en = (i == 3);
      go(1);
      ok = 1;
      stp = 0;
      for (a = 0; a <= LA; a = a + 1) begin
        nd = i_otp_dev_model.need[a];
        ep = stp ? 1 : (nd > 11 ? 11 : nd);
        if (!stp && nd > 11) begin
          ok = 0;
          stp = 1;
        end
        check(i_otp_dev_model.cnt[a], ep);
        check(i_otp_dev_model.mem[a], ep >= nd ? src[a] : 8'hFF);
      end
      check(i_otp_dev_model.cnt[LA+1], 0);
      check(pass_r, ok && !weak_en);
    end
    weak_en = 1'b0;
    go(0);
    check(maker_code_r, 8'hA5);
    check(type_code_r, 8'h3C);
    wrap_up;
  end
endmodule // tb
